// [rtl/sct_defs.vh]
// Constants for the smart card timer0 extended modes block
// Functional notes
// R1: Mode 0101: any START bit starts count; at zero set flag, reload, wait next START.
// R2: Mode 0110: like 0101 but only received START bits start the count.
// R3: With live reload set, each zero crossing loads the newest reload count.
// R4: Down-count time-out lasts reload count plus one ETU.
// R5: Mode 0111 starts at first START bit either direction, runs until enable cleared.
// R6: Mode 0111: each further START bit reloads the count and restarts counting.
// R7: Mode 0111: reaching zero before next START bit raises the interrupt flag.
// R8: Mode 0111 counts only after a START following enable set; stops on clear.
// R9: Mode 1000 counts up while enabled; result kept in 24-bit capture field.
// R10: Mode 1000 never raises the interrupt flag.
// R11: Elapsed up-count equals captured value plus one; reader adds one.
// R12: Up-count starts at zero and ignores the reload count.
// R13: Clearing enable in mode 1000 stops counting and captures the final value.
// R14: Reload count is a 24-bit field in ETU units.
// R15: Mode 0001 one-shot on any START; 0010 on received START; end at time-out.
`ifndef SCT_DEFS_VH
`define SCT_DEFS_VH
`define SCT_CNT_W 24
`define SCT_MODE_W 4
`define SCT_MODE_ONE_ANY 4'h1
`define SCT_MODE_ONE_RX 4'h2
`define SCT_MODE_RPT_ANY 4'h5
`define SCT_MODE_RPT_RX 4'h6
`define SCT_MODE_GAP 4'h7
`define SCT_MODE_UP 4'h8
`define SCT_CNT_RST 24'h000000
`endif

// [rtl/sct_timer0.v]
// Timer0 of the smart card host: start-bit triggered and up-count modes
`timescale 1ns/1ps
`include "sct_defs.vh"
module sct_timer0
(
   input wire i_clock, // 40 MHz system clock
   input wire i_rst, // Asynchronous reset, active high
   input wire i_etu_tick, // One-cycle pulse per ETU
   input wire i_start_rx, // Pulse: received START bit detected
   input wire i_start_tx, // Pulse: transmitted START bit detected
   input wire i_timer0_run_enable, // Run enable from software
   input wire i_timer0_live_reload, // Live reload option
   input wire [3:0] i_mode, // Operating mode
   input wire [23:0] i_reload_count, // Reload count, ETU units
   input wire i_irq_flag_clear, // Pulse: software clears flag
   output reg o_timer0_irq_flag, // Sticky time-out flag
   output reg o_run_enable_clear, // Pulse: hardware ends the run
   output reg o_counting, // Counter active
   output reg [23:0] o_count, // Live counter value
   output reg [23:0] o_captured_duration // Up-count capture
);
   localparam ST_IDLE = 2'h0;
   localparam ST_WAIT = 2'h1;
   localparam ST_RUN = 2'h2;
   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg [23:0] cnt_r;
   reg [23:0] cnt_nxt;
   reg [23:0] shadow_r;
   reg run_d_r;
   reg set_flag;
   reg end_run;
   wire start_any;
   wire start_sel;
   wire rx_only;
   wire is_up;
   wire [23:0] load_val;
   wire arm;
   wire at_zero;
   wire is_one_shot;
   wire is_gap;
   wire stop_up;

   // Start-bit qualification per mode
   assign start_any = i_start_rx | i_start_tx;
   assign rx_only = (i_mode == `SCT_MODE_ONE_RX) || (i_mode == `SCT_MODE_RPT_RX);
   assign start_sel = rx_only ? i_start_rx : start_any; // [R15] [R2] [R5]
   assign is_up = (i_mode == `SCT_MODE_UP);
   // Newest count when live reload is set, else value latched at run start
   assign load_val = i_timer0_live_reload ? i_reload_count : shadow_r; // [R3] [R14]
   // Mode groups: the one-shots end the run at time-out, the gap mode
   // keeps counting and treats every START bit as a restart
   assign is_one_shot = (i_mode == `SCT_MODE_ONE_ANY) || (i_mode == `SCT_MODE_ONE_RX);
   assign is_gap = (i_mode == `SCT_MODE_GAP);
   // Arm on a rising run enable, seen against its registered copy, and again after a one-shot end
   assign arm = (state_r == ST_IDLE) && i_timer0_run_enable && !run_d_r; // [R8] [R9]
   // Zero is a counted ETU of its own, hence the extra unit of time-out
   assign at_zero = (cnt_r == `SCT_CNT_RST); // [R4]
   // An up run ends on the first cycle the enable is seen low
   assign stop_up = is_up && (state_r == ST_RUN) && !i_timer0_run_enable; // [R13]

   // Next state and counter value
   always @*
   begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      set_flag = 1'b0;
      end_run = 1'b0;
      case (state_r)
         ST_IDLE:
         begin
            if (arm)
            begin
               if (is_up)
               begin
                  state_nxt = ST_RUN;
                  cnt_nxt = `SCT_CNT_RST; // [R12]
               end
               else
               begin
                  state_nxt = ST_WAIT; // [R8]
                  cnt_nxt = i_reload_count;
               end
            end
         end
         ST_WAIT:
         begin
            if (start_sel)
            begin
               state_nxt = ST_RUN; // [R1] [R2] [R5] [R8]
               cnt_nxt = load_val;
            end
         end
         default:
         begin
            if (is_up)
            begin
               if (i_etu_tick)
                  cnt_nxt = cnt_r + 24'h000001; // [R9]
            end
            else if (is_gap && start_sel)
               cnt_nxt = load_val; // [R6]
            else if (i_etu_tick)
            begin
               // Zero is a counted ETU, so time-out spans count plus one
               if (at_zero)
               begin
                  set_flag = 1'b1; // [R4] [R7]
                  cnt_nxt = load_val; // [R3]
                  if (is_one_shot)
                  begin
                     state_nxt = ST_IDLE; // [R15]
                     end_run = 1'b1;
                  end
                  else if (!is_gap)
                     state_nxt = ST_WAIT; // [R1] [R2]
               end
               else
                  cnt_nxt = cnt_r - 24'h000001; // [R4]
            end
         end
      endcase
      if (!i_timer0_run_enable)
      begin
         state_nxt = ST_IDLE; // [R8] [R5]
         set_flag = 1'b0;
         end_run = 1'b0;
      end
   end

   // Phase and counter registers; next values come from the block above
   always @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         state_r <= ST_IDLE;
         cnt_r <= `SCT_CNT_RST;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Reload copy taken at arm time; used when live reload is off, so a
   // count rewritten mid-run does not disturb the run in progress
   always @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         shadow_r <= `SCT_CNT_RST;
      end
      else if (arm)
      begin
         shadow_r <= i_reload_count; // [R3] [R14]
      end
   end

   // Enable history for arming; a one-shot end clears it so that software
   // which leaves the enable high re-arms instead of hanging in idle
   always @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         run_d_r <= 1'b0;
      end
      else
      begin
         run_d_r <= i_timer0_run_enable & !end_run;
      end
   end

   // Sticky time-out flag; a set wins over a clear in the same cycle so
   // that no time-out is lost, and the up mode never sets it
   always @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_timer0_irq_flag <= 1'b0;
      end
      else if (set_flag && !is_up)
      begin
         o_timer0_irq_flag <= 1'b1; // [R7] [R10]
      end
      else if (i_irq_flag_clear)
      begin
         o_timer0_irq_flag <= 1'b0;
      end
   end

   // Status outputs, registered from the next-state values so that they
   // line up with the phase and counter flops
   always @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_run_enable_clear <= 1'b0;
         o_counting <= 1'b0;
         o_count <= `SCT_CNT_RST;
      end
      else
      begin
         o_run_enable_clear <= end_run; // [R15]
         o_counting <= (state_nxt == ST_RUN);
         o_count <= cnt_nxt;
      end
   end

   // Capture of the final up-count; it holds until the next up run ends,
   // and the reader adds one to get the elapsed ETUs
   always @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_captured_duration <= `SCT_CNT_RST;
      end
      else if (stop_up)
      begin
         o_captured_duration <= cnt_r; // [R13] [R11] [R9]
      end
   end
endmodule // sct_timer0

// [tb/sct_timer0_checker.sv]
// Assertion checker for the timer0 extended modes
`timescale 1ns/1ps
module sct_timer0_checker(
input wire i_clock,i_rst,i_etu_tick,i_start_rx,i_start_tx,i_timer0_run_enable,
input wire i_timer0_live_reload,i_irq_flag_clear,o_timer0_irq_flag,o_run_enable_clear,o_counting,
input wire [3:0] i_mode,
input wire [23:0] i_reload_count,o_count,o_captured_duration);
default clocking @(posedge i_clock); endclocking
default disable iff (i_rst);
wire up=i_mode==4'h8;
wire run=o_counting&&i_timer0_run_enable;
chk_up_no_irq: assert property (up && !o_timer0_irq_flag |=> !o_timer0_irq_flag)
else $error("flag set in up mode");
chk_up_from_zero: assert property (up && $rose(o_counting) |-> o_count==24'h0)
else $error("up count not from zero");
chk_up_step: assert property (up && run && i_etu_tick |=> o_count==$past(o_count)+24'h1)
else $error("up step wrong");
chk_up_capture: assert property (up && o_counting && !i_timer0_run_enable && !i_etu_tick
|=> !o_counting && o_captured_duration==$past(o_count)) else $error("capture wrong");
chk_down_step: assert property (i_mode==4'h7 && run && i_etu_tick && o_count!=24'h0
&& !i_start_rx && !i_start_tx |=> o_count==$past(o_count)-24'h1) else $error("down step");
chk_zero_flag: assert property (!up && run && i_etu_tick && o_count==24'h0
&& !(i_mode==4'h7 && (i_start_rx||i_start_tx)) |=> o_timer0_irq_flag)
else $error("no flag at zero");
chk_oneshot_end: assert property ((i_mode==4'h1||i_mode==4'h2) && run && i_etu_tick
&& o_count==24'h0 |=> o_run_enable_clear && !o_counting) else $error("one-shot did not end");
chk_gap_reload: assert property (i_mode==4'h7 && run && i_timer0_live_reload
&& (i_start_rx||i_start_tx) |=> o_count==$past(i_reload_count)) else $error("no reload");
chk_stop_run: assert property (!i_timer0_run_enable |=> !o_counting)
else $error("counting while disabled");
// Main scenarios reached
cover property (i_mode==4'h7 && run && i_start_rx);
cover property ($rose(o_timer0_irq_flag));
cover property (up && $fell(o_counting));
cover property ($rose(o_run_enable_clear));
endmodule // sct_timer0_checker
bind sct_timer0 sct_timer0_checker i_sct_timer0_checker(.*);

// [tb/sct_card_line.sv]
// Card-line partner: ETU ticks and START bit pulses
`timescale 1ns/1ps
module sct_card_line(
   input wire i_clock, // System clock
   output reg o_tick=0, // ETU pulse
   output reg o_rx=0, // Received START pulse
   output reg o_tx=0 // Sent START pulse
);
   reg [1:0] n=0;
   // One tick every four clocks, launched at the falling edge
   always @(negedge i_clock)
   begin
      n<=n+2'h1;
      o_tick<=(n==2'h0);
   end
   // Wait for a phase whose next rising edge has no tick
   task align; do @(negedge i_clock); while (n!=2'h2); endtask
   // One-cycle START pulse
   task start(input rx);
   begin
      align;
      o_rx<=rx;
      o_tx<=!rx;
      @(negedge i_clock);
      o_rx<=0;
      o_tx<=0;
   end
   endtask
endmodule // sct_card_line

// [tb/tb.sv]
// Self-checking bench for the timer0 extended modes
`timescale 1ns/1ps
module tb;
reg i_clock=0,i_rst=1,i_timer0_run_enable=0,i_timer0_live_reload=0,i_irq_flag_clear=0;
reg [3:0] i_mode=4'h5;
reg [23:0] i_reload_count=24'h2;
wire i_etu_tick,i_start_rx,i_start_tx,o_timer0_irq_flag,o_run_enable_clear,o_counting;
wire [23:0] o_count,o_captured_duration;
int mismatches=0,cmp_count=0,n;
always #12.5 i_clock=~i_clock;
sct_card_line i_sct_card_line(.i_clock(i_clock),.o_tick(i_etu_tick),.o_rx(i_start_rx),
.o_tx(i_start_tx));
sct_timer0 i_sct_timer0(.*);
task chk(input [23:0] seen,exp); begin cmp_count++; if (seen!==exp) begin mismatches++;
$display("Error %0t: saw %h want %h",$time,seen,exp); end end endtask
task en(input v); begin @(negedge i_clock); i_timer0_run_enable=v; @(negedge i_clock); end endtask
task clr; begin @(negedge i_clock); i_irq_flag_clear=1; @(negedge i_clock); i_irq_flag_clear=0; end endtask
// Count ETU ticks seen while counting until the flag rises
task to_flag; begin n=0; repeat (300) if (o_timer0_irq_flag!==1'b1) begin @(posedge i_clock);
n+=i_etu_tick&&o_counting; #1; end end endtask
// Repeating one-shot: sent START ignored in receive-only mode
task t_rpt(input [3:0] m); begin i_mode=m; en(1); i_sct_card_line.start(0);
chk(o_counting,m==4'h5);
if (m==4'h6) i_sct_card_line.start(1);
to_flag; chk(n,3); chk(o_counting,0); clr; chk(o_timer0_irq_flag,0);
i_sct_card_line.start(1); chk(o_counting,1); en(0); chk(o_counting,0); end endtask
// Gap time-out with live reload
task t_gap; begin i_mode=4'h7; i_timer0_live_reload=1; i_reload_count=24'h3; en(1);
chk(o_counting,0); i_sct_card_line.start(1); i_reload_count=24'h6;
i_sct_card_line.start(0); chk(o_count,6); i_reload_count=24'h5;
to_flag; chk(n,7); chk(o_counting,1); chk(o_count,5);
en(0); chk(o_counting,0); clr; end endtask
// One-shot: time-out ends the run; the count is the one latched at arm
task t_one(input [3:0] m); begin i_mode=m; i_timer0_live_reload=0; i_reload_count=24'h2;
en(1); i_reload_count=24'h9; i_sct_card_line.start(0); chk(o_counting,m==4'h1);
if (m==4'h2) i_sct_card_line.start(1);
to_flag; chk(n,3); chk(o_run_enable_clear,1); chk(o_counting,0);
en(0); chk(o_run_enable_clear,0); clr; chk(o_timer0_irq_flag,0); end endtask
// Up count: arm edge is the first; ticks fall on edges 3, 7 .. 39, ten in all
task t_up; begin i_mode=4'h8; i_sct_card_line.align; i_timer0_run_enable=1;
repeat (40) @(posedge i_clock);
en(0); chk(o_captured_duration,24'ha); chk(o_counting,0);
chk(o_timer0_irq_flag,0); end endtask
task end_of_test; begin $display("checks %0d mismatches %0d",cmp_count,mismatches);
if (mismatches==0&&cmp_count>0) $display("Test passed"); else $display("Test failed");
$finish; end endtask
initial begin repeat (5) @(negedge i_clock); i_rst=0;
t_rpt(4'h5); t_rpt(4'h6); t_one(4'h1); t_one(4'h2); t_gap; t_up; end_of_test; end
initial begin #400000; mismatches++; end_of_test; end
endmodule // tb
